// File: bfps_regs.svh
// constants, register map and timing figures of the fault-protection sequencer
`ifndef BFPS_REGS_SVH
`define BFPS_REGS_SVH

// register byte offsets
`define BFPS_OFS_CTRL 5'h00
`define BFPS_OFS_STATUS 5'h04
`define BFPS_OFS_IRQ_STAT 5'h08
`define BFPS_OFS_IRQ_MASK 5'h0c

// control fields
`define BFPS_CTRL_EN_BIT 0
`define BFPS_CTRL_RST 8'h01
`define BFPS_MASK_RST 8'h00

// status fields
`define BFPS_ST_STATE_LSB 0
`define BFPS_ST_LEVEL_LSB 4
`define BFPS_ST_SW_BIT 8
`define BFPS_ST_DIS_BIT 9
`define BFPS_ST_HZ_BIT 10
`define BFPS_ST_HVDIS_BIT 11
`define BFPS_ST_PHASE_BIT 12

// interrupt event bits
`define BFPS_EV_VIN_OVP 0
`define BFPS_EV_VOUT_OVP 1
`define BFPS_EV_HICCUP 2
`define BFPS_EV_BROWN 3
`define BFPS_EV_THERM 4
`define BFPS_EV_W 5

// timing
`define BFPS_CLK_KHZ 10000
`define BFPS_T_VIN_OVP_MS 40
`define BFPS_T_UV_DEGLITCH_US 10
`define BFPS_T_HICCUP_MS 4130
`define BFPS_T_BROWN_MS 450
`define BFPS_T_BLANK_US 3500
`define BFPS_T_DISCHARGE_MS 100
`define BFPS_CNT_W 26

`endif

// File: bfps_pkg.sv
// types shared by the fault-protection sequencer
`default_nettype none
package bfps_pkg;
    typedef enum logic [2:0] {
        BFPS_IDLE = 3'h0,
        BFPS_RUN = 3'h1,
        BFPS_OVP_WAIT = 3'h3,
        BFPS_HICCUP = 3'h2,
        BFPS_BROWN = 3'h6
    } bfps_state_t;

    typedef enum logic [1:0] {
        BFPS_LVL_5V1 = 2'h0,
        BFPS_LVL_9V1 = 2'h1,
        BFPS_LVL_12V1 = 2'h2
    } bfps_level_t;

    // digitised comparator results, all active high
    typedef struct packed {
        logic vin_ovp;
        logic vin_lockout;
        logic vin_below_8v;
        logic vin_above_8v2;
        logic vout_ovp;
        logic vout_uv;
        logic vout_below_3v7;
        logic vout_above_3v9;
        logic over_temp;
        logic hs_peak_limit;
    } bfps_cmp_t;
endpackage
`default_nettype wire

// File: bfps_timer.sv
// interval counter: counts while run, cleared by restart, frozen by hold
`timescale 1ns/1ps
`default_nettype none
`include "bfps_regs.svh"
module bfps_timer import bfps_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic hold,
    input wire logic [`BFPS_CNT_W-1:0] limit,
    // result
    output logic done
);
    logic [`BFPS_CNT_W-1:0] cnt_q;
    logic done_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else if (!run || restart) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else if (!hold) begin
            if (cnt_q != limit) begin
                cnt_q <= cnt_q + `BFPS_CNT_W'(1);
            end
            done_q <= (cnt_q + `BFPS_CNT_W'(1) >= limit);
        end
    end

    assign done = done_q;
endmodule
`default_nettype wire

// File: bfps_level_sel.sv
// output level choice from the select pin or the fast-charge decoder
`timescale 1ns/1ps
`default_nettype none
`include "bfps_regs.svh"
module bfps_level_sel import bfps_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // requests
    input wire logic pin_high,
    input wire logic pin_low,
    input wire logic fcp_active,
    input wire bfps_level_t fcp_level,
    input wire logic hv_block,
    // result
    output bfps_level_t level_q,
    output logic drop_q
);
    bfps_level_t level_d;

    always_comb begin
        if (hv_block) begin
            level_d = BFPS_LVL_5V1;
        end else if (fcp_active) begin
            level_d = fcp_level;
        end else if (pin_high && !pin_low) begin
            level_d = BFPS_LVL_12V1;
        end else if (pin_low && !pin_high) begin
            level_d = BFPS_LVL_9V1;
        end else begin
            level_d = BFPS_LVL_5V1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level_q <= BFPS_LVL_5V1;
            drop_q <= 1'b0;
        end else begin
            level_q <= level_d;
            drop_q <= (level_d < level_q);
        end
    end

    a_level_high: assert property (@(posedge core_clk) disable iff (rst)
        (!hv_block && !fcp_active && pin_high && !pin_low) |=> level_q == BFPS_LVL_12V1)
        else $error("pin high did not select the top level");
endmodule
`default_nettype wire

// File: bfps_seq.sv
// fault-protection and restart sequencer with its register slave
`timescale 1ns/1ps
`default_nettype none
`include "bfps_regs.svh"
module bfps_seq import bfps_pkg::*; #(
    parameter int OVP_RESUME_CYC = `BFPS_T_VIN_OVP_MS * `BFPS_CLK_KHZ,
    parameter int HICCUP_CYC = `BFPS_T_HICCUP_MS * `BFPS_CLK_KHZ,
    parameter int BROWN_CYC = `BFPS_T_BROWN_MS * `BFPS_CLK_KHZ,
    parameter int BLANK_CYC = (`BFPS_T_BLANK_US * `BFPS_CLK_KHZ + 999) / 1000,
    parameter int DISCHARGE_CYC = `BFPS_T_DISCHARGE_MS * `BFPS_CLK_KHZ
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // comparators and level requests
    input wire bfps_cmp_t cmp,
    input wire logic output_level_select_pin_high,
    input wire logic output_level_select_pin_low,
    input wire logic fast_charge_protocol_mode,
    input wire bfps_level_t fcp_level,
    input wire logic sw_cycle_start,
    // power stage control
    output logic sw_enable_q,
    output logic hs_gate_q,
    output logic discharge_q,
    output bfps_level_t out_level_q,
    output logic hv_disable_q,
    output logic renegotiate_q,
    output logic high_impedance_state_q,
    output logic irq_q,
    // axi4-lite slave
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int UV_CYC = (`BFPS_T_UV_DEGLITCH_US * `BFPS_CLK_KHZ + 999) / 1000;

    bfps_state_t state_q, state_d;
    bfps_cmp_t cmp_q;
    logic phase_on_q, therm_q, dis_win_q;
    logic [7:0] ctrl_q, mask_q;
    logic [`BFPS_EV_W-1:0] stat_q, ev, rd_clr;
    logic m_run, m_restart, m_done, brown_rst, hv_active;
    logic blank_done, uv_done, good_done, dis_done, level_drop;
    logic [`BFPS_CNT_W-1:0] m_limit;
    logic [4:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_have_q, w_have_q;

    function automatic logic addr_mapped(input logic [4:0] a);
        return a == `BFPS_OFS_CTRL || a == `BFPS_OFS_STATUS ||
            a == `BFPS_OFS_IRQ_STAT || a == `BFPS_OFS_IRQ_MASK;
    endfunction

    // freezing state and timers on over-temperature keeps timer progress intact
    assign hv_active = out_level_q != BFPS_LVL_5V1;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            therm_q <= 1'b0;
            cmp_q <= '0;
        end else begin
            therm_q <= cmp.over_temp;
            cmp_q <= cmp;
        end
    end

    always_comb begin
        state_d = state_q;
        if (!ctrl_q[`BFPS_CTRL_EN_BIT] || cmp.vin_lockout) begin
            state_d = BFPS_IDLE;
        end else begin
            unique case (state_q)
                BFPS_IDLE: state_d = BFPS_RUN;
                BFPS_RUN: begin
                    if (cmp.vin_ovp) begin
                        state_d = BFPS_OVP_WAIT;
                    end else if (uv_done) begin
                        state_d = BFPS_HICCUP;
                    end else if (hv_active && m_done) begin
                        state_d = BFPS_BROWN;
                    end
                end
                BFPS_OVP_WAIT: if (m_done && !cmp.vin_ovp) state_d = BFPS_RUN;
                BFPS_HICCUP: if (m_done) state_d = BFPS_RUN;
                BFPS_BROWN: begin
                    if (cmp.vin_ovp) begin
                        state_d = BFPS_OVP_WAIT;
                    end else if (good_done) begin
                        state_d = BFPS_RUN;
                    end
                end
                default: state_d = BFPS_IDLE;
            endcase
        end
        if (cmp.over_temp) begin
            state_d = state_q;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= BFPS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign brown_rst = state_q == BFPS_BROWN && (phase_on_q ?
        (cmp.vout_above_3v9 && !cmp_q.vout_above_3v9 && cmp.vin_below_8v) :
        (cmp.vout_below_3v7 && !cmp_q.vout_below_3v7));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_on_q <= 1'b0;
        end else if (state_q != BFPS_BROWN || cmp.over_temp) begin
            phase_on_q <= phase_on_q && state_q == BFPS_BROWN;
        end else if (m_done && !brown_rst) begin
            // off again if input still low
            if (!phase_on_q || cmp.vin_below_8v) begin
                phase_on_q <= !phase_on_q;
            end
        end
    end

    always_comb begin
        m_run = 1'b1;
        m_limit = `BFPS_CNT_W'(BROWN_CYC);
        unique case (state_q)
            BFPS_IDLE: m_run = 1'b0;
            BFPS_RUN: m_run = hv_active && cmp.vin_below_8v && !cmp.vin_lockout;
            BFPS_OVP_WAIT: begin
                m_run = !cmp.vin_ovp;
                m_limit = `BFPS_CNT_W'(OVP_RESUME_CYC);
            end
            BFPS_HICCUP: m_limit = `BFPS_CNT_W'(HICCUP_CYC);
            BFPS_BROWN: m_run = 1'b1;
            default: m_run = 1'b0;
        endcase
    end

    assign m_restart = (state_d != state_q) || brown_rst ||
        (state_q == BFPS_BROWN && m_done);

    bfps_timer u_main (.core_clk(core_clk), .rst(rst), .run(m_run),
        .restart(m_restart), .hold(cmp.over_temp), .limit(m_limit), .done(m_done));

    bfps_timer u_blank (.core_clk(core_clk), .rst(rst), .run(state_q == BFPS_RUN),
        .restart(state_d != state_q), .hold(cmp.over_temp),
        .limit(`BFPS_CNT_W'(BLANK_CYC)), .done(blank_done));

    bfps_timer u_uv (.core_clk(core_clk), .rst(rst),
        .run(state_q == BFPS_RUN && blank_done && cmp.vout_uv),
        .restart(1'b0), .hold(cmp.over_temp), .limit(`BFPS_CNT_W'(UV_CYC)), .done(uv_done));

    bfps_timer u_good (.core_clk(core_clk), .rst(rst),
        .run(state_q == BFPS_BROWN && cmp.vin_above_8v2), .restart(1'b0),
        .hold(cmp.over_temp), .limit(`BFPS_CNT_W'(BROWN_CYC)), .done(good_done));

    bfps_timer u_dis (.core_clk(core_clk), .rst(rst), .run(dis_win_q),
        .restart(level_drop), .hold(cmp.over_temp),
        .limit(`BFPS_CNT_W'(DISCHARGE_CYC)), .done(dis_done));

    bfps_level_sel u_level (.core_clk(core_clk), .rst(rst),
        .pin_high(output_level_select_pin_high), .pin_low(output_level_select_pin_low),
        .fcp_active(fast_charge_protocol_mode), .fcp_level(fcp_level),
        .hv_block(hv_disable_q), .level_q(out_level_q), .drop_q(level_drop));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sw_enable_q <= 1'b0;
            hs_gate_q <= 1'b0;
            hv_disable_q <= 1'b0;
            renegotiate_q <= 1'b0;
            high_impedance_state_q <= 1'b0;
        end else begin
            sw_enable_q <= !cmp.over_temp && !cmp.vout_ovp && !cmp.vin_ovp &&
                (state_d == BFPS_RUN || (state_d == BFPS_BROWN && phase_on_q));
            if (cmp.hs_peak_limit || !sw_enable_q || cmp.over_temp) begin
                hs_gate_q <= 1'b0;
            end else if (sw_cycle_start) begin
                hs_gate_q <= 1'b1;
            end
            if (state_d == BFPS_BROWN) begin
                hv_disable_q <= 1'b1;
            end else if (state_d == BFPS_RUN || state_d == BFPS_IDLE) begin
                hv_disable_q <= 1'b0;
            end
            renegotiate_q <= state_q == BFPS_BROWN && state_d == BFPS_RUN;
            high_impedance_state_q <= cmp.over_temp;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dis_win_q <= 1'b0;
            discharge_q <= 1'b0;
        end else begin
            if (level_drop) begin
                dis_win_q <= 1'b1;
            end else if (dis_done) begin
                dis_win_q <= 1'b0;
            end
            discharge_q <= !cmp.over_temp && (cmp.vout_ovp || level_drop || dis_win_q);
        end
    end

    // sticky events; a new event beats a read clear
    always_comb begin
        ev = '0;
        ev[`BFPS_EV_VIN_OVP] = state_d == BFPS_OVP_WAIT && state_q != BFPS_OVP_WAIT;
        ev[`BFPS_EV_VOUT_OVP] = cmp.vout_ovp && !cmp_q.vout_ovp;
        ev[`BFPS_EV_HICCUP] = state_d == BFPS_HICCUP && state_q != BFPS_HICCUP;
        ev[`BFPS_EV_BROWN] = state_d == BFPS_BROWN && state_q != BFPS_BROWN;
        ev[`BFPS_EV_THERM] = cmp.over_temp && !therm_q;
    end

    assign rd_clr = {`BFPS_EV_W{s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == `BFPS_OFS_IRQ_STAT}};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~rd_clr) | ev;
            irq_q <= |(((stat_q & ~rd_clr) | ev) & mask_q[`BFPS_EV_W-1:0]);
        end
    end

    // write side: address and data in either order, one write at a time
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            ctrl_q <= `BFPS_CTRL_RST;
            mask_q <= `BFPS_MASK_RST;
        end else begin
            s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_have_q && !s_axi_bvalid;
            s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_have_q && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (aw_have_q && w_have_q && !s_axi_bvalid) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_mapped(aw_addr_q) ? 2'h0 : 2'h2;
                if (w_strb_q[0] && aw_addr_q == `BFPS_OFS_CTRL) begin
                    ctrl_q <= w_data_q[7:0];
                end
                if (w_strb_q[0] && aw_addr_q == `BFPS_OFS_IRQ_MASK) begin
                    mask_q <= w_data_q[7:0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read side
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= addr_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
                s_axi_rdata <= '0;
                unique case (s_axi_araddr)
                    `BFPS_OFS_CTRL: s_axi_rdata[7:0] <= ctrl_q;
                    `BFPS_OFS_STATUS: begin
                        s_axi_rdata[`BFPS_ST_STATE_LSB +: 3] <= state_q;
                        s_axi_rdata[`BFPS_ST_LEVEL_LSB +: 2] <= out_level_q;
                        s_axi_rdata[`BFPS_ST_SW_BIT] <= sw_enable_q;
                        s_axi_rdata[`BFPS_ST_DIS_BIT] <= discharge_q;
                        s_axi_rdata[`BFPS_ST_HZ_BIT] <= high_impedance_state_q;
                        s_axi_rdata[`BFPS_ST_HVDIS_BIT] <= hv_disable_q;
                        s_axi_rdata[`BFPS_ST_PHASE_BIT] <= phase_on_q;
                    end
                    `BFPS_OFS_IRQ_STAT: s_axi_rdata[`BFPS_EV_W-1:0] <= stat_q;
                    `BFPS_OFS_IRQ_MASK: s_axi_rdata[7:0] <= mask_q;
                    default: s_axi_rdata <= '0;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    a_vin_ovp_stop: assert property (@(posedge core_clk) disable iff (rst)
        cmp.vin_ovp |=> !sw_enable_q) else $error("switching on during input over-voltage");
    a_ovp_resume_wait: assert property (@(posedge core_clk) disable iff (rst)
        (state_q == BFPS_OVP_WAIT && cmp.vin_ovp) |=> state_q != BFPS_RUN)
        else $error("resumed while input over-voltage still present");
    a_vout_ovp_disch: assert property (@(posedge core_clk) disable iff (rst)
        (cmp.vout_ovp && !cmp.over_temp) |=> discharge_q && !sw_enable_q)
        else $error("output over-voltage without discharge or with switching");
    a_drop_disch: assert property (@(posedge core_clk) disable iff (rst)
        (level_drop && !cmp.over_temp) |=> discharge_q) else $error("level drop not discharged");
    a_uv_hiccup: assert property (@(posedge core_clk) disable iff (rst)
        (uv_done && state_q == BFPS_RUN && !cmp.vin_ovp && !cmp.over_temp &&
        ctrl_q[`BFPS_CTRL_EN_BIT] && !cmp.vin_lockout) |=> state_q == BFPS_HICCUP ##1 !sw_enable_q)
        else $error("deglitched under-voltage did not start hiccup");
    a_hiccup_off: assert property (@(posedge core_clk) disable iff (rst)
        (state_q == BFPS_HICCUP && $past(state_q) == BFPS_HICCUP) |-> !sw_enable_q)
        else $error("switching during hiccup wait");
    a_brown_hv_off: assert property (@(posedge core_clk) disable iff (rst)
        $rose(state_q == BFPS_BROWN) |-> hv_disable_q ##2 out_level_q == BFPS_LVL_5V1)
        else $error("brownout left high-voltage mode on");
    a_therm_freeze: assert property (@(posedge core_clk) disable iff (rst)
        (cmp.over_temp && $past(cmp.over_temp)) |=> $stable(state_q) && high_impedance_state_q
        && !sw_enable_q) else $error("over-temperature state not frozen off");
    a_peak_cut: assert property (@(posedge core_clk) disable iff (rst)
        cmp.hs_peak_limit |=> !hs_gate_q) else $error("high side on past peak limit");
    a_blank_uv: assert property (@(posedge core_clk) disable iff (rst)
        (state_q == BFPS_RUN && !blank_done) |-> !uv_done) else $error("under-voltage not blanked");
    c_hiccup: cover property (@(posedge core_clk) disable iff (rst) ev[`BFPS_EV_HICCUP]);
    c_brown_exit: cover property (@(posedge core_clk) disable iff (rst) renegotiate_q);
    c_ovp_resume: cover property (@(posedge core_clk) disable iff (rst)
        state_q == BFPS_OVP_WAIT ##1 state_q == BFPS_RUN);
    c_level_drop: cover property (@(posedge core_clk) disable iff (rst) level_drop);
endmodule
`default_nettype wire

// File: bfps_stage.sv
// power stage stand-in: level pin, switching period, peak current
`timescale 1ns/1ps
`default_nettype none
module bfps_stage (
    // clock and pin drive: 0 float, 1 high, 2 low
    input wire logic core_clk,
    input wire logic [1:0] pin_mode,
    input wire logic hs_gate_q,
    // to sequencer
    output logic pin_high,
    output logic pin_low,
    output logic cyc_start,
    output logic peak
);
    logic [3:0] ph_q = 4'h0;
    assign pin_high = pin_mode == 2'h1;
    assign pin_low = pin_mode == 2'h2;
    // current ramps to the limit at count 5 of the 16-count period
    always_ff @(posedge core_clk) begin
        ph_q <= ph_q + 4'h1;
        cyc_start <= ph_q == 4'h0;
        peak <= hs_gate_q && ph_q == 4'h5;
    end
endmodule
`default_nettype wire

// File: buck_fault_protection_sequencer_test.sv
// self-checking bench for the fault-protection sequencer
`timescale 1ns/1ps
`default_nettype none
module buck_fault_protection_sequencer_test import bfps_pkg::*;;
    logic core_clk, rst, fcp, ph, pl, cs, pk, awv, wv, bv, br, arv, rv, rr, sw, hg, dis, hv, rn, hz, irq;
    logic awr, wr_rdy, arr;
    logic [3:0] ws;
    logic [1:0] pm, bresp, rresp;
    logic [4:0] awa, ara;
    logic [31:0] wd, rd_d, v;
    bfps_cmp_t cmp, cmp_in;
    bfps_level_t lvl, fl;
    int error_cnt = 0, n_compared = 0, c;
    bfps_stage stage (.core_clk(core_clk), .pin_mode(pm), .hs_gate_q(hg), .pin_high(ph),
        .pin_low(pl), .cyc_start(cs), .peak(pk));
    // peak current comes from the stage model
    assign cmp_in = {cmp[9:1], pk};
    bfps_seq #(.OVP_RESUME_CYC(50), .HICCUP_CYC(80), .BROWN_CYC(60), .BLANK_CYC(30),
        .DISCHARGE_CYC(40)) uut (.core_clk(core_clk), .rst(rst), .cmp(cmp_in),
        .output_level_select_pin_high(ph), .output_level_select_pin_low(pl),
        .fast_charge_protocol_mode(fcp), .fcp_level(fl), .sw_cycle_start(cs),
        .sw_enable_q(sw), .hs_gate_q(hg), .discharge_q(dis), .out_level_q(lvl),
        .hv_disable_q(hv), .renegotiate_q(rn), .high_impedance_state_q(hz), .irq_q(irq),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr));
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // waits for sw_enable_q to reach a level, c = cycles taken
    task automatic wt(input logic l, input int n);
        for (c = 0; c < n && sw !== l; c++) tick(1);
        if (c == n) begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        for (c = 0; c < 50; c++) begin
            tick(1);
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
            if (bv) break;
        end
        br <= 1'b0;
        if (c == 50) begin
            error_cnt++;
            give_verdict();
        end
        chk("bresp", 2'h0, bresp);
        // one idle edge so a following call never re-drives bready in this step
        tick(1);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        for (c = 0; c < 50; c++) begin
            tick(1);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        d = rd_d; r = rresp; rr <= 1'b0;
        if (c == 50) begin
            error_cnt++;
            give_verdict();
        end
        tick(1);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        logic [1:0] r;
        rst = 1'b1; cmp = '0; fcp = 1'b0; pm = 2'h0; awv = 1'b0; wv = 1'b0; br = 1'b0;
        arv = 1'b0; rr = 1'b0; awa = '0; ara = '0; wd = '0; ws = 4'hf; fl = BFPS_LVL_5V1;
        tick(3);
        rst <= 1'b0;
        tick(1);
        rd(5'h00, v, r); chk("ctrl", 32'h1, v);
        rd(5'h0c, v, r); chk("mask", 32'h0, v);
        rd(5'h14, v, r); chk("unmapped", 2'h2, r);
        chk("unmapped data", 32'h0, v);
        wr(5'h0c, 32'h1f);
        ws <= 4'h0; wr(5'h0c, 32'h0);
        rd(5'h0c, v, r); chk("strobe off", 32'h1f, v);
        wt(1'b1, 100);
        for (c = 0; c < 40 && pk !== 1'b1; c++) tick(1);
        chk("peak seen", 1, c < 40);
        chk("gate on", 1, hg);
        tick(1); chk("peak cut", 0, hg);
        cmp.vin_ovp <= 1'b1; tick(2); chk("ovp off", 0, sw);
        chk("irq", 1, irq);
        rd(5'h08, v, r); chk("ovp event", 32'h1, v);
        cmp.vin_ovp <= 1'b0; wt(1'b1, 100); chk("ovp wait", 1, c >= 48 && c <= 53);
        cmp.vout_ovp <= 1'b1; tick(2); chk("out ovp", 0, sw);
        chk("ovp sink", 1, dis);
        cmp.vout_ovp <= 1'b0; wt(1'b1, 10); chk("ovp back", 1, sw);
        pm <= 2'h2; tick(3); chk("pin low", BFPS_LVL_9V1, lvl);
        pm <= 2'h1; tick(3); chk("pin high", BFPS_LVL_12V1, lvl);
        fcp <= 1'b1; fl <= BFPS_LVL_9V1; tick(3); chk("fcp lvl", BFPS_LVL_9V1, lvl);
        chk("fcp sink", 1, dis);
        fcp <= 1'b0; tick(3);
        cmp.vin_below_8v <= 1'b1; tick(66); chk("brownout", 1, hv);
        chk("brown lvl", BFPS_LVL_5V1, lvl);
        chk("drop sink", 1, dis);
        cmp.vout_below_3v7 <= 1'b1; wt(1'b1, 100);
        chk("collapse wait", 1, c >= 62 && c <= 66);
        cmp.vout_below_3v7 <= 1'b0; cmp.vout_above_3v9 <= 1'b1; wt(1'b0, 100);
        chk("recovery wait", 1, c >= 62 && c <= 66);
        cmp.vout_above_3v9 <= 1'b0; cmp.vin_below_8v <= 1'b0; cmp.vin_above_8v2 <= 1'b1;
        for (c = 0; c < 200 && rn !== 1'b1; c++) tick(1);
        chk("renegotiate", 1, c >= 59 && c < 200);
        tick(2); chk("hv back", 0, hv);
        pm <= 2'h0; cmp.vout_uv <= 1'b1; wt(1'b0, 300);
        chk("uv time", 1, c >= 100);
        cmp.vout_uv <= 1'b0; wt(1'b1, 200); chk("hiccup", 1, c >= 78 && c <= 85);
        cmp.over_temp <= 1'b1; tick(2); chk("hz", 1, hz);
        chk("hz off", 0, sw);
        cmp.over_temp <= 1'b0; wt(1'b1, 300);
        give_verdict();
    end
endmodule
`default_nettype wire
